// ===== src/ber_pkg.sv
package ber_pkg;

  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [11:0] OFF_CHK_CTRL = 12'h500;
  localparam logic [11:0] OFF_GEN_CTRL = 12'h504;
  localparam logic [11:0] OFF_PAT_LO = 12'h508;
  localparam logic [11:0] OFF_PAT_HI = 12'h50C;
  localparam logic [11:0] OFF_BC_LO = 12'h510;
  localparam logic [11:0] OFF_BC_HI = 12'h514;
  localparam logic [11:0] OFF_EVT = 12'h520;
  localparam logic [11:0] OFF_EC_LO = 12'h524;
  localparam logic [11:0] OFF_EC_HI = 12'h528;

  // ---------------------------------------------------------------
  // field positions, masks and reset values
  // ---------------------------------------------------------------
  localparam int CHK_RESYNC = 0;
  localparam int CHK_LATCH = 1;
  localparam int CHK_PS_LSB = 2;
  localparam int CHK_RXINV = 5;
  localparam int CHK_TXINV = 6;
  localparam int CHK_RPL_LSB = 8;
  localparam int CHK_OVERFLOW_IRQ_EN = 13;
  localparam int CHK_BIT_ERROR_IRQ_EN = 14;
  localparam int CHK_SYNC_CHANGE_IRQ_EN = 15;
  localparam int GEN_LOAD = 0;
  localparam int GEN_SBE = 4;
  localparam int GEN_ERATE_LSB = 5;
  localparam int GEN_AWC_LSB = 8;
  localparam int EVT_SYNC = 0;
  localparam int EVT_EOVF = 1;
  localparam int EVT_BOVF = 2;
  localparam int EVT_BERR = 3;
  localparam int EVT_SCHG = 4;
  localparam logic [15:0] CHK_MASK = 16'hEF7F;
  localparam logic [15:0] GEN_MASK = 16'hFFF1;
  localparam logic [15:0] REG_RESET = 16'h0000;
  localparam logic [7:0] AWC_MIN = 8'h05;

  // ---------------------------------------------------------------
  // pattern and synchroniser constants
  // ---------------------------------------------------------------
  localparam logic [5:0] REP_LEN_BASE = 6'h11;
  localparam logic [5:0] SYNC_MATCH = 6'h20;
  localparam logic [6:0] WIN_LEN = 7'h40;
  localparam logic [2:0] WIN_ERR = 3'h6;
  localparam int QRSS_RUN = 14;
  localparam int TAP7_A = 6;
  localparam int TAP7_B = 5;
  localparam int TAP11_A = 10;
  localparam int TAP11_B = 8;
  localparam int TAP15_A = 14;
  localparam int TAP15_B = 13;
  localparam int TAP20_A = 19;
  localparam int TAP20_B = 16;
  localparam int WORD_BITS = 16;
  // error insertion period per rate code, one in ten up to ten million
  localparam logic [7:0][23:0] ERR_DIV = {
    24'h989680, 24'h0F4240, 24'h0186A0, 24'h002710,
    24'h0003E8, 24'h000064, 24'h00000A, 24'h000000};

  typedef enum logic [2:0] {
    PAT_P7 = 3'b000,
    PAT_P11 = 3'b001,
    PAT_P15 = 3'b010,
    PAT_QRSS = 3'b011,
    PAT_REP = 3'b100,
    PAT_ALT = 3'b101,
    PAT_BAD6 = 3'b110,
    PAT_BAD7 = 3'b111
  } ber_pat_e;

  typedef struct packed {
    logic [4:0] pos;
    logic [7:0] rep;
    logic sel;
  } ber_ptr_s;

  // step through a repetitive or alternating pattern
  function automatic ber_ptr_s next_ptr(ber_pat_e m, ber_ptr_s p,
                                        logic [5:0] len, logic [7:0] cnt);
    ber_ptr_s n;
    n = p;
    if (m == PAT_REP) begin
      n.pos = (p.pos == 5'(len - 6'h01)) ? 5'h00 : p.pos + 5'h01;
    end else if (m == PAT_ALT) begin
      n.pos = {1'b0, p.pos[3:0] + 4'h1};
      if (p.pos[3:0] == 4'hF) begin
        if (p.rep == cnt - 8'h01) begin
          n.rep = 8'h00;
          n.sel = ~p.sel;
        end else begin
          n.rep = p.rep + 8'h01;
        end
      end
    end
    return n;
  endfunction

  // expected next bit; s holds past bits, newest in bit 0
  function automatic logic ref_bit(ber_pat_e m, ber_ptr_s p,
                                   logic [31:0] pat, logic [19:0] s);
    logic b;
    b = 1'b0;
    unique case (m)
      PAT_P7: b = s[TAP7_A] ^ s[TAP7_B];
      PAT_P11: b = s[TAP11_A] ^ s[TAP11_B];
      PAT_P15: b = s[TAP15_A] ^ s[TAP15_B];
      PAT_QRSS: b = (s[QRSS_RUN-1:0] == '0) | (s[TAP20_A] ^ s[TAP20_B]);
      PAT_REP: b = pat[p.pos];
      PAT_ALT: b = pat[{p.sel, p.pos[3:0]}];
      default: b = 1'b0;
    endcase
    return b;
  endfunction

endpackage

// ===== src/ber_link_if.sv
`timescale 1ns/1ps
interface ber_link_if;
  logic regSel;
  logic regWrite;
  logic [11:0] regAddr;
  logic [15:0] regWdata;
  logic [15:0] regRdata;
  logic regAck;
  logic txBit;
  logic txValid;
  logic txReady;
  logic rxBit;
  logic rxValid;
  logic irq;

  modport tester (input regSel, regWrite, regAddr, regWdata,
                  output regRdata, regAck, txBit, txValid, irq,
                  input txReady, rxBit, rxValid);
  modport host (output regSel, regWrite, regAddr, regWdata,
                input regRdata, regAck, txBit, txValid, irq,
                output txReady, rxBit, rxValid);
endinterface

// ===== src/ber_tester.sv
// Overview of operation
// RULE_01 - rx invert bit flips incoming bits
// RULE_02 - tx invert bit flips outgoing bits
// RULE_03 - repetitive length is seventeen plus code
// RULE_04 - length field ignored for pseudorandom patterns
// RULE_05 - short patterns use a multiple length
// RULE_06 - overflow interrupt enable gates counter overflows
// RULE_07 - bit error interrupt enable gates errors
// RULE_08 - sync change interrupt on gain and loss
// RULE_09 - rising load bit reloads the generator
// RULE_10 - rising single error bit flips one bit
// RULE_11 - rate field inserts errors automatically
// RULE_12 - alternating words repeat count times each
// RULE_13 - alternating count kept within 05h to FFh
// RULE_14 - 32-bit pattern shared by generator, checker
// RULE_15 - short patterns replicated, lsb sent first
// RULE_16 - pseudorandom seed words are all ones
// RULE_17 - low and high words alternate
// RULE_18 - bit count read as two words
// RULE_19 - control, pattern, count registers reset zero
// RULE_20 - bit counter counts every bit, saturates
// RULE_21 - rising latch bit copies, clears counts
// RULE_22 - pattern select codes, two illegal
// RULE_23 - sync at 32 matches, lost at 6/64
// RULE_24 - irq is OR of enabled sticky events
`timescale 1ns/1ps
module ber_tester (
  input wire logic clock, // system clock
  input wire logic resetn, // async reset, active low
  ber_link_if.tester link, // registers and bit streams
  output logic inSync // checker locked
);

  // ---------------------------------------------------------------
  // register decode
  // ---------------------------------------------------------------
  logic [15:0] chkCtrl, genCtrl, patLo, patHi;
  logic [31:0] bitCnt, bitLatched;
  logic [23:0] errCnt, errLatched;
  logic evtEovf, evtBovf, evtBerr, evtSchg;
  logic prevResync, prevLatch, prevLoad, prevSbe;
  wire logic wrEn = link.regSel & link.regWrite;
  wire logic wrChk = wrEn & (link.regAddr == ber_pkg::OFF_CHK_CTRL);
  wire logic wrGen = wrEn & (link.regAddr == ber_pkg::OFF_GEN_CTRL);
  wire logic wrPatLo = wrEn & (link.regAddr == ber_pkg::OFF_PAT_LO);
  wire logic wrPatHi = wrEn & (link.regAddr == ber_pkg::OFF_PAT_HI);
  wire logic wrEvt = wrEn & (link.regAddr == ber_pkg::OFF_EVT);
  wire logic [31:0] pat32 = {patHi, patLo}; // RULE_14 RULE_17
  wire logic resyncEdge = chkCtrl[ber_pkg::CHK_RESYNC] & ~prevResync;
  wire logic latchEdge = chkCtrl[ber_pkg::CHK_LATCH] & ~prevLatch; // RULE_21
  wire logic loadEdge = genCtrl[ber_pkg::GEN_LOAD] & ~prevLoad; // RULE_09
  wire logic sbeEdge = genCtrl[ber_pkg::GEN_SBE] & ~prevSbe; // RULE_10
  // RULE_22
  wire ber_pkg::ber_pat_e mode =
    ber_pkg::ber_pat_e'(chkCtrl[ber_pkg::CHK_PS_LSB +: 3]);
  wire logic legal = (mode != ber_pkg::PAT_BAD6) &
                     (mode != ber_pkg::PAT_BAD7);
  // only the repetitive branch of next_ptr reads the length
  wire logic [5:0] repLen = ber_pkg::REP_LEN_BASE +
    {2'h0, chkCtrl[ber_pkg::CHK_RPL_LSB +: 4]}; // RULE_03 RULE_04 RULE_05
  wire logic [7:0] awc = genCtrl[ber_pkg::GEN_AWC_LSB +: 8];
  wire logic [2:0] erate = genCtrl[ber_pkg::GEN_ERATE_LSB +: 3];
  wire logic [15:0] evtWord = {11'h000, evtSchg, evtBerr, evtBovf,
                               evtEovf, inSync};
  wire logic [15:0] rdMux =
    (link.regAddr == ber_pkg::OFF_CHK_CTRL) ? chkCtrl :
    (link.regAddr == ber_pkg::OFF_GEN_CTRL) ? genCtrl :
    (link.regAddr == ber_pkg::OFF_PAT_LO) ? patLo :
    (link.regAddr == ber_pkg::OFF_PAT_HI) ? patHi :
    (link.regAddr == ber_pkg::OFF_BC_LO) ? bitLatched[15:0] : // RULE_18
    (link.regAddr == ber_pkg::OFF_BC_HI) ? bitLatched[31:16] : // RULE_18
    (link.regAddr == ber_pkg::OFF_EVT) ? evtWord :
    (link.regAddr == ber_pkg::OFF_EC_LO) ? errLatched[15:0] :
    (link.regAddr == ber_pkg::OFF_EC_HI) ? {8'h00, errLatched[23:16]} :
    16'h0000;

  // control registers; n/a bits stay zero
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      chkCtrl <= ber_pkg::REG_RESET; // RULE_19
      genCtrl <= ber_pkg::REG_RESET; // RULE_19
      patLo <= ber_pkg::REG_RESET; // RULE_19
      patHi <= ber_pkg::REG_RESET; // RULE_19
    end else begin
      if (wrChk) chkCtrl <= link.regWdata & ber_pkg::CHK_MASK;
      if (wrGen) genCtrl <= link.regWdata & ber_pkg::GEN_MASK;
      if (wrPatLo) patLo <= link.regWdata;
      if (wrPatHi) patHi <= link.regWdata;
    end
  end

  // edge history of the strobe bits, answer one cycle after select
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      {prevResync, prevLatch, prevLoad, prevSbe} <= 4'h0;
      link.regAck <= 1'b0;
      link.regRdata <= 16'h0000;
    end else begin
      prevResync <= chkCtrl[ber_pkg::CHK_RESYNC];
      prevLatch <= chkCtrl[ber_pkg::CHK_LATCH];
      prevLoad <= genCtrl[ber_pkg::GEN_LOAD];
      prevSbe <= genCtrl[ber_pkg::GEN_SBE];
      link.regAck <= link.regSel;
      link.regRdata <= link.regSel ? rdMux : 16'h0000;
    end
  end

  // ---------------------------------------------------------------
  // generator
  // ---------------------------------------------------------------
  ber_pkg::ber_ptr_s gPtr;
  logic [19:0] gLfsr;
  logic [23:0] gErrCnt;
  logic sbePend, outBit, outValid, spareBit, spareValid;
  wire logic push = ~spareValid; // a full spare entry stalls the generator
  wire logic genBit = ber_pkg::ref_bit(mode, gPtr, pat32, gLfsr);
  wire logic errTick = (erate != 3'h0) &
    (gErrCnt >= ber_pkg::ERR_DIV[erate] - 24'h000001); // RULE_11
  wire logic txData = genBit ^ errTick ^ sbePend ^
    chkCtrl[ber_pkg::CHK_TXINV]; // RULE_02 RULE_10
  wire logic pop = outValid & link.txReady;

  // pattern state advances only when a bit enters the buffer
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      gLfsr <= 20'h00000;
      gPtr <= '0;
      gErrCnt <= 24'h000000;
    end else if (loadEdge) begin
      gLfsr <= pat32[19:0]; // RULE_09 RULE_16
      gPtr <= '0; // RULE_15
      gErrCnt <= 24'h000000;
    end else if (push) begin
      gLfsr <= {gLfsr[18:0], genBit};
      gPtr <= ber_pkg::next_ptr(mode, gPtr, repLen, awc); // RULE_12
      gErrCnt <= (errTick | erate == 3'h0) ? 24'h000000 :
                 gErrCnt + 24'h000001; // RULE_11
    end
  end

  // a new request wins over consumption of the old one
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) sbePend <= 1'b0;
    else sbePend <= sbeEdge | (sbePend & ~push); // RULE_10
  end

  // two-entry buffer: head drives the link, spare absorbs a stall
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      {outBit, outValid, spareBit, spareValid} <= 4'h0;
    end else if (pop) begin
      if (spareValid) begin
        outBit <= spareBit;
        spareValid <= 1'b0;
      end else begin
        outBit <= txData;
      end
    end else if (!outValid) begin
      outBit <= txData;
      outValid <= 1'b1;
    end else if (push) begin
      spareBit <= txData;
      spareValid <= 1'b1;
    end
  end
  assign link.txBit = outBit;
  assign link.txValid = outValid;

  // ---------------------------------------------------------------
  // checker
  // ---------------------------------------------------------------
  ber_pkg::ber_ptr_s cPtr;
  logic [19:0] hist;
  logic [5:0] matchCnt;
  logic [6:0] winCnt;
  logic [2:0] winErr;
  wire logic rxB = link.rxBit ^ chkCtrl[ber_pkg::CHK_RXINV]; // RULE_01
  wire logic expBit = ber_pkg::ref_bit(mode, cPtr, pat32, hist);
  wire logic miss = link.rxValid & legal & (rxB != expBit);
  wire logic gainSync = link.rxValid & ~inSync & ~miss & ~resyncEdge &
    (matchCnt == ber_pkg::SYNC_MATCH - 6'h01); // RULE_23
  wire logic loseSync = (resyncEdge & inSync) |
    (link.rxValid & inSync & miss &
     (winErr == ber_pkg::WIN_ERR - 3'h1)); // RULE_23
  wire logic errHit = link.rxValid & inSync & miss;
  wire logic winEnd = winCnt == ber_pkg::WIN_LEN - 7'h01;

  // hunting slips the pattern pointer on each mismatch
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      {inSync, hist, matchCnt, winCnt, winErr} <= '0;
      cPtr <= '0;
    end else if (resyncEdge) begin
      {inSync, matchCnt, winCnt, winErr} <= '0;
    end else if (link.rxValid) begin
      hist <= {hist[18:0], rxB};
      if (!inSync && miss) begin
        matchCnt <= 6'h00;
      end else begin
        cPtr <= ber_pkg::next_ptr(mode, cPtr, repLen, awc);
        matchCnt <= gainSync ? 6'h00 : matchCnt + {5'h00, ~inSync};
      end
      inSync <= (inSync & ~loseSync) | gainSync;
      winCnt <= (inSync & ~loseSync & ~winEnd) ? winCnt + 7'h01 : 7'h00;
      winErr <= (winEnd | loseSync | ~inSync) ? 3'h0 :
                winErr + {2'h0, miss};
    end
  end

  // ---------------------------------------------------------------
  // counters, sticky events and interrupt
  // ---------------------------------------------------------------
  wire logic bitFull = &bitCnt;
  wire logic errFull = &errCnt;
  wire logic bitOvfHit = link.rxValid & bitFull & ~latchEdge; // RULE_20
  wire logic errOvfHit = errHit & errFull & ~latchEdge;

  // the bit count runs while hunting too, errors count only in sync; a latch restarts both
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      {bitCnt, bitLatched} <= '0; // RULE_19
      {errCnt, errLatched} <= '0;
    end else if (latchEdge) begin
      bitLatched <= bitCnt; // RULE_21
      errLatched <= errCnt; // RULE_21
      bitCnt <= {31'h00000000, link.rxValid};
      errCnt <= {23'h000000, errHit};
    end else begin
      if (link.rxValid && !bitFull) bitCnt <= bitCnt + 32'h00000001; // RULE_20
      if (errHit && !errFull) errCnt <= errCnt + 24'h000001;
    end
  end

  // write one to clear; a same-cycle event keeps the flag set
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      {evtEovf, evtBovf, evtBerr, evtSchg, link.irq} <= 5'h00;
    end else begin
      evtEovf <= errOvfHit |
        (evtEovf & ~(wrEvt & link.regWdata[ber_pkg::EVT_EOVF]));
      evtBovf <= bitOvfHit |
        (evtBovf & ~(wrEvt & link.regWdata[ber_pkg::EVT_BOVF])); // RULE_20
      evtBerr <= errHit |
        (evtBerr & ~(wrEvt & link.regWdata[ber_pkg::EVT_BERR]));
      evtSchg <= gainSync | loseSync |
        (evtSchg & ~(wrEvt & link.regWdata[ber_pkg::EVT_SCHG])); // RULE_08
      link.irq <=
        (chkCtrl[ber_pkg::CHK_OVERFLOW_IRQ_EN] & (evtEovf | evtBovf)) | // RULE_06
        (chkCtrl[ber_pkg::CHK_BIT_ERROR_IRQ_EN] & evtBerr) | // RULE_07
        (chkCtrl[ber_pkg::CHK_SYNC_CHANGE_IRQ_EN] & evtSchg); // RULE_08 RULE_24
    end
  end

endmodule // ber_tester

// ===== src/ber_host.sv
`timescale 1ns/1ps
module ber_host (
  input wire logic clock, // system clock
  input wire logic resetn, // async reset, active low
  ber_link_if.host link, // registers and bit streams
  input wire logic cmdValid, // register command offered
  input wire logic cmdWrite, // 1 write, 0 read
  input wire logic [11:0] cmdAddr, // register offset
  input wire logic [15:0] cmdData, // write data
  output logic cmdReady, // command can be taken
  output logic rspValid, // one-cycle answer pulse
  output logic [15:0] rspData, // read data
  output logic userTxBit, // generated bit to user
  output logic userTxValid, // generated bit present
  input wire logic userTxReady, // user takes the bit
  input wire logic userRxBit, // bit for the checker
  input wire logic userRxValid, // checker bit present
  output logic irqOut // interrupt request copy
);

  typedef enum logic {HST_IDLE = 1'b0, HST_WAIT = 1'b1} ber_hst_e;
  ber_hst_e state;

  // ---------------------------------------------------------------
  // register commands
  // ---------------------------------------------------------------
  wire logic take = cmdValid & cmdReady;
  wire logic genWr = cmdWrite & (cmdAddr == ber_pkg::OFF_GEN_CTRL);
  wire logic awcLow =
    cmdData[ber_pkg::GEN_AWC_LSB +: 8] < ber_pkg::AWC_MIN;
  // keep the alternating count legal, a short count starves sync
  wire logic [15:0] wrData = (genWr & awcLow) ?
    {ber_pkg::AWC_MIN, cmdData[7:0]} : cmdData; // RULE_13

  // one select pulse per command, then wait for the answer
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state <= HST_IDLE;
      {cmdReady, rspValid, link.regSel, link.regWrite} <= 4'h0;
      link.regAddr <= 12'h000;
      {link.regWdata, rspData} <= 32'h00000000;
    end else begin
      rspValid <= 1'b0;
      link.regSel <= 1'b0;
      unique case (state)
        HST_IDLE: begin
          cmdReady <= ~take;
          if (take) begin
            link.regSel <= 1'b1;
            link.regWrite <= cmdWrite;
            link.regAddr <= cmdAddr;
            link.regWdata <= wrData;
            state <= HST_WAIT;
          end
        end
        HST_WAIT: begin
          if (link.regAck) begin
            rspValid <= 1'b1;
            rspData <= link.regRdata;
            cmdReady <= 1'b1;
            state <= HST_IDLE;
          end
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // bit streams
  // ---------------------------------------------------------------
  wire logic txTake = link.txValid & link.txReady;
  wire logic txDrop = userTxValid & userTxReady;
  wire logic next_hold = txTake | (userTxValid & ~txDrop);

  // one holding stage; a user stall reaches the generator buffer
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      {userTxBit, userTxValid, link.txReady} <= 3'h0;
      {link.rxBit, link.rxValid, irqOut} <= 3'h0;
    end else begin
      if (txTake) userTxBit <= link.txBit;
      userTxValid <= next_hold;
      link.txReady <= ~next_hold;
      link.rxBit <= userRxBit;
      link.rxValid <= userRxValid;
      irqOut <= link.irq;
    end
  end

endmodule // ber_host

// ===== verification/ber_link_checker.sv
`timescale 1ns/1ps
module ber_link_checker (
  input wire logic clock, // clock
  input wire logic resetn, // reset
  input wire logic regSel, // select
  input wire logic regWrite, // write
  input wire logic [11:0] regAddr, // offset
  input wire logic [15:0] regWdata, // wdata
  input wire logic [15:0] regRdata, // rdata
  input wire logic regAck, // answer
  input wire logic txBit, // tx bit
  input wire logic txValid, // tx valid
  input wire logic txReady, // tx ready
  input wire logic rxValid, // rx valid
  input wire logic irq, // request
  input wire logic inSync // locked
);
  // ------------------------------------------------------------
  // shadows of written registers and the hunting run length
  // ------------------------------------------------------------
  logic [15:0] chkCopy;
  logic [15:0] genCopy;
  logic [15:0] patLo;
  logic [7:0] huntRun;
  wire wrStb = regSel & regWrite;
  wire [2:0] enMask = chkCopy[15:13];
  // run saturates so a long hunt never wraps below the lock figure
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      chkCopy <= 16'h0000;
      genCopy <= 16'h0000;
      patLo <= 16'h0000;
      huntRun <= 8'h00;
    end else begin
      if (wrStb && regAddr == 12'h500) chkCopy <= regWdata & 16'hEF7F;
      if (wrStb && regAddr == 12'h504) genCopy <= regWdata & 16'hFFF1;
      if (wrStb && regAddr == 12'h508) patLo <= regWdata;
      if (inSync) huntRun <= 8'h00;
      else if (rxValid && huntRun != 8'hFF) huntRun <= huntRun + 8'h01;
    end
  end
  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  sequence read_of(logic [11:0] a);
    regSel && !regWrite && regAddr == a;
  endsequence
  sequence answer_is(logic [15:0] v);
    regAck && regRdata == v;
  endsequence
  ack_after_sel_a: assert property (regSel |=> regAck)
    else $error("register answer missing");
  ack_needs_sel_a: assert property (regAck |-> $past(regSel))
    else $error("answer without request");
  rdata_idle_a: assert property (!regAck |-> regRdata == 16'h0000)
    else $error("read data outside answer");
  pat_readback_a: assert property (
    read_of(12'h508) |=> answer_is(patLo))
    else $error("pattern word readback");
  gen_readback_a: assert property (
    read_of(12'h504) |=> answer_is(genCopy))
    else $error("generator control readback");
  chk_readback_a: assert property (
    read_of(12'h500) |=> answer_is(chkCopy))
    else $error("checker control readback");
  tx_hold_a: assert property (
    txValid && !txReady |=> txValid && $stable(txBit))
    else $error("stalled bit lost");
  sync_run_a: assert property (
    $rose(inSync) |-> huntRun >= 8'h20)
    else $error("lock with short run");
  sync_irq_a: assert property (
    $changed(inSync) && chkCopy[15] |-> ##[1:3] irq)
    else $error("sync change gave no request");
  irq_masked_a: assert property (
    enMask == 3'b000 && $past(enMask) == 3'b000 |-> !irq)
    else $error("request while all masked");
endmodule // ber_link_checker

// ===== verification/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic cmdValid = 1'b0;
  logic cmdWrite = 1'b0;
  logic [11:0] cmdAddr = 12'h000;
  logic [15:0] cmdData = 16'h0000;
  logic userTxReady = 1'b0;
  logic userRxBit = 1'b0;
  logic userRxValid = 1'b0;
  logic cmdReady, rspValid, userTxBit, userTxValid, irqOut, inSync;
  logic [15:0] rspData;
  logic [15:0] q;
  logic [15:0] cfg;
  logic [31:0] rng = 32'h3E42;
  logic [31:0] rxCnt = 32'h0;
  logic [31:0] n0;
  logic loopOn = 1'b0;
  logic capOn = 1'b0;
  logic capQ[$];
  logic [11:0] regs [7] = '{12'h500, 12'h504, 12'h508, 12'h50C, 12'h510,
                            12'h514, 12'h530};
  int error_cnt = 0;
  int total_checks = 0;
  ber_link_if link();
  ber_tester i_ber_tester(.clock, .resetn, .link(link), .inSync);
  ber_host i_ber_host(.clock, .resetn, .link(link), .cmdValid, .cmdWrite,
    .cmdAddr, .cmdData, .cmdReady, .rspValid, .rspData, .userTxBit,
    .userTxValid, .userTxReady, .userRxBit, .userRxValid, .irqOut);
  ber_link_checker i_ber_link_checker(.clock, .resetn,
    .regSel(link.regSel), .regWrite(link.regWrite), .regAddr(link.regAddr),
    .regWdata(link.regWdata), .regRdata(link.regRdata),
    .regAck(link.regAck), .txBit(link.txBit), .txValid(link.txValid),
    .txReady(link.txReady), .rxValid(link.rxValid), .irq(link.irq),
    .inSync);
  always #5 clock = ~clock;
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  // some rotation of the replicated word must explain every captured bit
  function automatic logic rot_ok(input logic [31:0] p, input int len);
    logic ok;
    rot_ok = 1'b0;
    for (int o = 0; o < len; o++) begin
      ok = capQ.size() >= 64;
      foreach (capQ[k]) if (capQ[k] !== p[(k + o) % len]) ok = 1'b0;
      if (ok) rot_ok = 1'b1;
    end
  endfunction
  // loopback with random stalls; ready drops with the loop so no
  // generated bit is taken without reaching the checker
  always @(posedge clock) begin
    rng <= xs(rng);
    userTxReady <= loopOn & (rng[0] | rng[1]);
    userRxValid <= userTxValid & userTxReady;
    userRxBit <= userTxBit;
    rxCnt <= rxCnt + {31'h0, userRxValid};
    if (capOn && userTxValid && userTxReady) capQ.push_back(userTxBit);
  end
  task automatic end_of_test();
    $display("checks %0d, errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // one command in flight; a stuck port ends the run
  task automatic reg_op(input logic wr, input logic [11:0] a,
                        input logic [15:0] d);
    int n;
    n = 0;
    while (cmdReady !== 1'b1 && n < 50) begin
      @(negedge clock);
      n++;
    end
    @(posedge clock);
    cmdValid <= 1'b1;
    cmdWrite <= wr;
    cmdAddr <= a;
    cmdData <= d;
    @(posedge clock);
    cmdValid <= 1'b0;
    do begin
      @(negedge clock);
      n++;
    end while (rspValid !== 1'b1 && n < 60);
    q = rspData;
    if (n >= 60) begin
      check(32'h0, 32'h1);
      end_of_test();
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    reg_op(1'b1, a, d);
  endtask
  task automatic rd(input logic [11:0] a);
    reg_op(1'b0, a, 16'h0000);
  endtask
  task automatic wait_sync(input logic lvl);
    int n;
    n = 0;
    while (inSync !== lvl && n < 20000) begin
      @(negedge clock);
      n++;
    end
    check({31'h0, inSync}, {31'h0, lvl});
    if (n >= 20000) end_of_test();
  endtask
  task automatic pause_loop();
    @(posedge clock);
    loopOn <= 1'b0;
    repeat (10) @(posedge clock);
  endtask
  task automatic latch();
    pause_loop();
    wr(12'h500, cfg);
    wr(12'h500, cfg | 16'h0002);
  endtask
  // resync waits out the select settling time before its strobe
  task automatic setup(input logic [31:0] p);
    pause_loop();
    wr(12'h508, p[15:0]);
    wr(12'h50C, p[31:16]);
    wr(12'h504, 16'h0500);
    wr(12'h504, 16'h0501);
    wr(12'h500, cfg);
    repeat (70) @(posedge clock);
    wr(12'h500, cfg | 16'h0001);
    wr(12'h520, 16'hFFFF);
    @(posedge clock);
    loopOn <= 1'b1;
  endtask
  initial begin
    repeat (10) @(posedge clock);
    resetn <= 1'b1;
    repeat (2) @(posedge clock);
    foreach (regs[i]) begin
      rd(regs[i]);
      check({16'h0, q}, 32'h0);
    end
    wr(12'h530, 16'hFFFF);
    rd(12'h530);
    check({16'h0, q}, 32'h0);
    wr(12'h504, 16'h0300);
    rd(12'h504);
    check({16'h0, q}, 32'h0500);
    for (int i = 0; i < 4; i++) begin
      cfg = rng[15:0];
      wr(12'h508, cfg);
      rd(12'h508);
      check({16'h0, q}, {16'h0, cfg});
      cfg = {8'h05 + {1'b0, rng[22:16]}, rng[7:0]};
      wr(12'h504, cfg);
      rd(12'h504);
      check({16'h0, q}, {16'h0, cfg & 16'hFFF1});
      cfg = rng[31:16];
      wr(12'h500, cfg);
      rd(12'h500);
      check({16'h0, q}, {16'h0, cfg & 16'hEF7F});
    end
    // every legal select but alternating; pseudorandom modes get a random length code
    for (int m = 0; m < 5; m++) begin
      cfg = {m != 0, 3'b000, (m == 4) ? 4'hD : rng[3:0], 1'b0, m[0], m[0],
             3'(m), 2'b00};
      setup((m == 4) ? 32'h5AD6B5AD : 32'hFFFFFFFF);
      wait_sync(1'b1);
      repeat (4) @(negedge clock);
      check({31'h0, irqOut}, {31'h0, m != 0});
      rd(12'h520);
      check({16'h0, q & 16'h0011}, 32'h11);
    end
    @(posedge clock);
    capOn <= 1'b1;
    for (int n = 0; n < 400 && capQ.size() < 64; n++) @(posedge clock);
    capOn <= 1'b0;
    check({31'h0, rot_ok(32'h5AD6B5AD, 30)}, 32'h1);
    cfg = cfg | 16'h4000;
    latch();
    wr(12'h520, 16'hFFFF);
    n0 = rxCnt;
    @(posedge clock);
    loopOn <= 1'b1;
    repeat (200) @(posedge clock);
    wr(12'h504, 16'h0510);
    repeat (200) @(posedge clock);
    latch();
    n0 = rxCnt - n0;
    rd(12'h510);
    check({16'h0, q}, {16'h0, n0[15:0]});
    rd(12'h514);
    check({16'h0, q}, {16'h0, n0[31:16]});
    rd(12'h524);
    check({16'h0, q}, 32'h1);
    rd(12'h520);
    check({16'h0, q & 16'h0009}, 32'h9);
    check({31'h0, irqOut}, 32'h1);
    @(posedge clock);
    loopOn <= 1'b1;
    wr(12'h504, 16'h0520);
    wait_sync(1'b0);
    wr(12'h504, 16'h0500);
    wait_sync(1'b1);
    wr(12'h500, cfg | 16'h0040);
    wait_sync(1'b0);
    wr(12'h500, cfg | 16'h0060);
    wait_sync(1'b1);
    end_of_test();
  end
endmodule // tb_top
